/* File: src/lpc_regs.svh */
// register offsets, instruction fields and codes of the low-power coprocessor core
`ifndef LPC_REGS_SVH
`define LPC_REGS_SVH

// register port offsets (byte addresses)
`define LPC_OFF_CTRL      8'h00
`define LPC_OFF_STATUS    8'h04
`define LPC_OFF_PC        8'h08
`define LPC_OFF_ENTRY     8'h0C
`define LPC_OFF_GPR0      8'h10
`define LPC_OFF_GPR1      8'h14
`define LPC_OFF_GPR2      8'h18
`define LPC_OFF_GPR3      8'h1C

// control and status bit positions
`define LPC_CTRL_START    0
`define LPC_CTRL_TMR_EN   1
`define LPC_STS_RUN       0
`define LPC_STS_ZERO      1
`define LPC_STS_OVF       2
`define LPC_STS_STG_LSB   8
`define LPC_STS_STG_MSB   15

// instruction fields
`define LPC_F_OP_MSB      31
`define LPC_F_OP_LSB      28
`define LPC_F_SUB_MSB     27
`define LPC_F_SUB_LSB     25
`define LPC_F_SEL_MSB     24
`define LPC_F_SEL_LSB     21
`define LPC_F_IMM_MSB     19
`define LPC_F_IMM_LSB     4
`define LPC_F_SIMM_MSB    11
`define LPC_F_SIMM_LSB    4
`define LPC_F_OFF_MSB     20
`define LPC_F_OFF_LSB     10
`define LPC_F_RS2_MSB     5
`define LPC_F_RS2_LSB     4
`define LPC_F_RS1_MSB     3
`define LPC_F_RS1_LSB     2
`define LPC_F_RD_MSB      1
`define LPC_F_RD_LSB      0
`define LPC_F_SSEL_MSB    22
`define LPC_F_SSEL_LSB    21
`define LPC_F_SHI_MSB     24
`define LPC_F_SHI_LSB     23

// value widths inside the register port and the datapath
`define LPC_WORD_MSB      10
`define LPC_GPR_MSB       15
`define LPC_SHAMT_MSB     3
`define LPC_OFF_SEXT      5
`define LPC_PC_STEP       11'h001

// operation codes and forms
`define LPC_OP_STORE      4'h6
`define LPC_OP_ALU        4'h7
`define LPC_OP_WAKE       4'h9
`define LPC_OP_HALT       4'hB
`define LPC_SUB_REG       3'h0
`define LPC_SUB_IMM       3'h1
`define LPC_SUB_STAGE     3'h2
`define LPC_SUB_WAKE      3'h0

// reset values
`define LPC_RST_PC        11'h000
`define LPC_RST_GPR       16'h0000
`define LPC_RST_STAGE     8'h00
`define LPC_RST_WORD      32'h0000_0000
`define LPC_HALF_ZERO     5'h00

`endif

/* File: src/lpc_pkg.sv */
// types shared by the low-power coprocessor core
package lpc_pkg;

  typedef enum logic [3:0] {
    LPC_SEL_ADD,
    LPC_SEL_SUB,
    LPC_SEL_AND,
    LPC_SEL_OR,
    LPC_SEL_MOVE,
    LPC_SEL_SHL,
    LPC_SEL_SHR
  } lpc_alu_operation_select_t;

  typedef enum logic [1:0] {
    LPC_STG_INC,
    LPC_STG_DEC,
    LPC_STG_RST
  } lpc_stage_sel_t;

  typedef enum {
    LPC_ST_IDLE,
    LPC_ST_FETCH,
    LPC_ST_FETCH_WAIT,
    LPC_ST_EXEC,
    LPC_ST_STORE
  } lpc_state_t;

  typedef logic [10:0] lpc_word_addr_t;
  typedef logic [15:0] lpc_gpr_t;

  typedef struct packed {
    lpc_state_t          state;
    lpc_word_addr_t      pc;
    lpc_word_addr_t      entry;
    logic [3:0][15:0]    gpr;
    logic [7:0]          stage;
    logic                zero;
    logic                ovf;
    logic                tmr_en;
    logic [31:0]         instr;
    lpc_word_addr_t      mem_addr;
    logic [31:0]         mem_wdata;
    logic [31:0]         rdata;
    logic                wake;
    logic                irq;
    logic                halted;
  } lpc_core_state_t;

endpackage

/* File: src/lpc_core.sv */
// fetch, decode and alu datapath of the low-power coprocessor core
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "lpc_regs.svh"
// Function
// RULE_01: decode 32-bit word, operation_code in top nibble
// RULE_02: four 16-bit general registers, 2-bit index
// RULE_03: separate 8-bit stage counter, alu-modifiable
// RULE_04: program and data in shared 8 KB memory
// RULE_05: program counter counts 32-bit words
// RULE_06: start by software or periodic timer
// RULE_07: halt instruction stops execution
// RULE_08: can wake core or interrupt cpu
// RULE_09: operation_code 7 form 0 uses registers
// RULE_10: select field picks add..right shift
// RULE_11: form 1 uses signed 16-bit immediate
// RULE_12: add and subtract update overflow flag
// RULE_13: every alu operation updates zero flag; the stage form (form 2) leaves it unchanged
// RULE_14: form 2 select 0 adds to stage
// RULE_15: stage select 1 subtracts immediate
// RULE_16: stage select 2 clears counter
// RULE_17: operation_code 6 stores source at base+offset
// RULE_18: store base register is word address
// RULE_19: stored word holds pc and source value
// RULE_20: immediate form shares register form selects
// RULE_21: logical shifts, stage wraps modulo 256
module lpc_core #(
  parameter int MEM_AW = 11
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  // register port
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [31:0]           i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output logic      [31:0]           o_reg_rdata,
  // timer start source and system sleep state
  input  wire logic                  i_timer_tick,
  input  wire logic                  i_soc_asleep,
  // shared slow memory
  output logic                       o_mem_rd,
  output logic                       o_mem_wr,
  output lpc_pkg::lpc_word_addr_t    o_mem_addr,
  output logic      [31:0]           o_mem_wdata,
  input  wire logic                  i_mem_gnt,
  input  wire logic [31:0]           i_mem_rdata,
  // events toward the system
  output logic                       o_wake_req,
  output logic                       o_cpu_irq,
  output logic                       o_halted,
  output logic                       o_running
);
  import lpc_pkg::*;

  // ==========================================================
  // state
  lpc_core_state_t q;
  lpc_core_state_t n;

  // ==========================================================
  // instruction fields
  logic [3:0]  op;
  logic [2:0]  form;
  logic [3:0]  sel;
  logic [1:0]  rs1_idx;
  logic [1:0]  rs2_idx;
  logic [1:0]  rd_idx;
  logic [15:0] imm16;
  logic [7:0]  stg_imm;
  logic [10:0] st_off;
  logic [1:0]  stg_sel;
  logic        stg_sel_ok;

  assign op      = q.instr[`LPC_F_OP_MSB:`LPC_F_OP_LSB]; // RULE_01
  assign form    = q.instr[`LPC_F_SUB_MSB:`LPC_F_SUB_LSB];
  assign sel     = q.instr[`LPC_F_SEL_MSB:`LPC_F_SEL_LSB];
  assign rs1_idx = q.instr[`LPC_F_RS1_MSB:`LPC_F_RS1_LSB]; // RULE_02
  assign rs2_idx = q.instr[`LPC_F_RS2_MSB:`LPC_F_RS2_LSB];
  assign rd_idx  = q.instr[`LPC_F_RD_MSB:`LPC_F_RD_LSB];
  assign imm16   = q.instr[`LPC_F_IMM_MSB:`LPC_F_IMM_LSB]; // RULE_11
  assign stg_imm = q.instr[`LPC_F_SIMM_MSB:`LPC_F_SIMM_LSB];
  assign st_off  = q.instr[`LPC_F_OFF_MSB:`LPC_F_OFF_LSB];
  // stage form only knows the low select codes
  assign stg_sel    = q.instr[`LPC_F_SSEL_MSB:`LPC_F_SSEL_LSB];
  assign stg_sel_ok = (q.instr[`LPC_F_SHI_MSB:`LPC_F_SHI_LSB] == 2'h0);

  // ==========================================================
  // alu datapath
  logic [15:0] opa;
  logic [15:0] opb;
  logic [16:0] sum;
  logic [16:0] diff;
  logic [15:0] alu_res;
  logic        alu_ok;
  logic        alu_arith;

  assign opa = q.gpr[rs1_idx];
  // immediate takes the place of the second register
  assign opb = (form == `LPC_SUB_IMM) ? imm16 : q.gpr[rs2_idx]; // RULE_09 RULE_20
  assign sum  = {1'b0, opa} + {1'b0, opb};
  assign diff = {1'b0, opa} - {1'b0, opb};

  always_comb begin
    alu_res   = `LPC_RST_GPR;
    alu_ok    = 1'b1;
    alu_arith = 1'b0;
    case (sel) // RULE_10
      LPC_SEL_ADD: begin
        alu_res   = sum[15:0];
        alu_arith = 1'b1;
      end
      LPC_SEL_SUB: begin
        alu_res   = diff[15:0];
        alu_arith = 1'b1;
      end
      LPC_SEL_AND: begin
        alu_res = opa & opb;
      end
      LPC_SEL_OR: begin
        alu_res = opa | opb;
      end
      LPC_SEL_MOVE: begin
        alu_res = opa;
      end
      LPC_SEL_SHL: begin
        alu_res = opa << opb[`LPC_SHAMT_MSB:0]; // RULE_21
      end
      LPC_SEL_SHR: begin
        alu_res = opa >> opb[`LPC_SHAMT_MSB:0]; // RULE_21
      end
      default: begin
        alu_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // store address and word
  logic [15:0] st_addr;
  logic [31:0] st_word;
  logic [15:0] st_off_ext;

  // offset sign carried up to the width of the base register
  assign st_off_ext = {{`LPC_OFF_SEXT{st_off[`LPC_F_OFF_MSB - `LPC_F_OFF_LSB]}}, st_off};
  // base register already counts words, offset is sign extended
  assign st_addr = q.gpr[rd_idx] + st_off_ext; // RULE_17 RULE_18
  assign st_word = {q.pc, `LPC_HALF_ZERO, q.gpr[rs1_idx]}; // RULE_19

  // ==========================================================
  // start request
  logic start_sw;
  logic start_go;

  assign start_sw = i_reg_wr && (i_reg_addr == `LPC_OFF_CTRL) &&
                    i_reg_wdata[`LPC_CTRL_START];
  assign start_go = start_sw || (i_timer_tick && q.tmr_en); // RULE_06

  // ==========================================================
  // next state
  always_comb begin
    n        = q;
    n.rdata  = `LPC_RST_WORD;
    n.wake   = 1'b0;
    n.irq    = 1'b0;
    n.halted = 1'b0;

    // register writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        `LPC_OFF_CTRL: begin
          n.tmr_en = i_reg_wdata[`LPC_CTRL_TMR_EN];
        end
        `LPC_OFF_ENTRY: begin
          n.entry = i_reg_wdata[`LPC_WORD_MSB:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, answer in the next cycle
    if (i_reg_rd) begin
      case (i_reg_addr)
        `LPC_OFF_CTRL: begin
          n.rdata[`LPC_CTRL_TMR_EN] = q.tmr_en;
        end
        `LPC_OFF_STATUS: begin
          n.rdata[`LPC_STS_RUN]  = (q.state != LPC_ST_IDLE);
          n.rdata[`LPC_STS_ZERO] = q.zero;
          n.rdata[`LPC_STS_OVF]  = q.ovf;
          n.rdata[`LPC_STS_STG_MSB:`LPC_STS_STG_LSB] = q.stage;
        end
        `LPC_OFF_PC: begin
          n.rdata[`LPC_WORD_MSB:0] = q.pc;
        end
        `LPC_OFF_ENTRY: begin
          n.rdata[`LPC_WORD_MSB:0] = q.entry;
        end
        `LPC_OFF_GPR0: begin
          n.rdata[`LPC_GPR_MSB:0] = q.gpr[0];
        end
        `LPC_OFF_GPR1: begin
          n.rdata[`LPC_GPR_MSB:0] = q.gpr[1];
        end
        `LPC_OFF_GPR2: begin
          n.rdata[`LPC_GPR_MSB:0] = q.gpr[2];
        end
        `LPC_OFF_GPR3: begin
          n.rdata[`LPC_GPR_MSB:0] = q.gpr[3];
        end
        default: begin
        end
      endcase
    end

    case (q.state)
      LPC_ST_IDLE: begin
        if (start_go) begin // RULE_06
          n.pc       = q.entry;
          n.mem_addr = q.entry;
          n.state    = LPC_ST_FETCH;
        end
      end
      LPC_ST_FETCH: begin
        // hold the read until the shared memory grants it
        if (i_mem_gnt) begin // RULE_04
          n.state = LPC_ST_FETCH_WAIT;
        end
      end
      LPC_ST_FETCH_WAIT: begin
        n.instr = i_mem_rdata;
        n.state = LPC_ST_EXEC;
      end
      LPC_ST_EXEC: begin
        // program counter advances by one word
        n.pc       = q.pc + `LPC_PC_STEP; // RULE_05
        n.mem_addr = q.pc + `LPC_PC_STEP;
        n.state    = LPC_ST_FETCH;
        case (op)
          `LPC_OP_ALU: begin
            case (form)
              `LPC_SUB_REG, `LPC_SUB_IMM: begin
                if (alu_ok) begin
                  n.gpr[rd_idx] = alu_res; // RULE_09 RULE_11
                  n.zero = (alu_res == `LPC_RST_GPR); // RULE_13
                  if (alu_arith) begin
                    // carry out of add, borrow out of subtract
                    n.ovf = (sel == LPC_SEL_ADD) ? sum[16] : diff[16]; // RULE_12
                  end
                end
              end
              `LPC_SUB_STAGE: begin
                if (stg_sel_ok) begin // RULE_03
                  case (stg_sel)
                    LPC_STG_INC: begin
                      n.stage = q.stage + stg_imm; // RULE_14 RULE_21
                    end
                    LPC_STG_DEC: begin
                      n.stage = q.stage - stg_imm; // RULE_15 RULE_21
                    end
                    LPC_STG_RST: begin
                      n.stage = `LPC_RST_STAGE; // RULE_16
                    end
                    default: begin
                    end
                  endcase
                end
              end
              default: begin
              end
            endcase
          end
          `LPC_OP_STORE: begin
            n.mem_addr  = st_addr[10:0];
            n.mem_wdata = st_word; // RULE_19
            n.state     = LPC_ST_STORE;
          end
          `LPC_OP_WAKE: begin
            if (form == `LPC_SUB_WAKE) begin
              // wake when asleep, otherwise interrupt the cpu
              n.wake = i_soc_asleep; // RULE_08
              n.irq  = !i_soc_asleep; // RULE_08
            end
          end
          `LPC_OP_HALT: begin
            // pc stays on the halt word for software to read
            n.pc     = q.pc;
            n.halted = 1'b1;
            n.state  = LPC_ST_IDLE; // RULE_07
          end
          default: begin
          end
        endcase
      end
      LPC_ST_STORE: begin
        if (i_mem_gnt) begin
          n.mem_addr = q.pc;
          n.state    = LPC_ST_FETCH;
        end
      end
      default: begin
        n.state = LPC_ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q.state     <= LPC_ST_IDLE;
      q.pc        <= `LPC_RST_PC;
      q.entry     <= `LPC_RST_PC;
      q.gpr       <= '0;
      q.stage     <= `LPC_RST_STAGE;
      q.zero      <= 1'b0;
      q.ovf       <= 1'b0;
      q.tmr_en    <= 1'b0;
      q.instr     <= `LPC_RST_WORD;
      q.mem_addr  <= `LPC_RST_PC;
      q.mem_wdata <= `LPC_RST_WORD;
      q.rdata     <= `LPC_RST_WORD;
      q.wake      <= 1'b0;
      q.irq       <= 1'b0;
      q.halted    <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // outputs
  assign o_reg_rdata = q.rdata;
  assign o_mem_rd    = (q.state == LPC_ST_FETCH);
  assign o_mem_wr    = (q.state == LPC_ST_STORE);
  assign o_mem_addr  = q.mem_addr;
  assign o_mem_wdata = q.mem_wdata;
  assign o_wake_req  = q.wake;
  assign o_cpu_irq   = q.irq;
  assign o_halted    = q.halted;
  assign o_running   = (q.state != LPC_ST_IDLE);

endmodule

/* File: testbench/lpc_core_props.sv */
// port assertions of the coprocessor core
`timescale 1ns/10ps
module lpc_core_props (
  input wire logic                    i_core_clk,
  input wire logic                    i_rst,
  input wire logic [7:0]              i_reg_addr,
  input wire logic [31:0]             i_reg_wdata,
  input wire logic                    i_reg_wr,
  input wire logic                    i_timer_tick,
  input wire logic                    o_mem_rd,
  input wire logic                    o_mem_wr,
  input wire lpc_pkg::lpc_word_addr_t o_mem_addr,
  input wire logic [31:0]             o_mem_wdata,
  input wire logic                    i_mem_gnt,
  input wire logic                    o_wake_req,
  input wire logic                    o_cpu_irq,
  input wire logic                    o_halted,
  input wire logic                    o_running
);
  import lpc_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ==========================================
  // helper state
  lpc_word_addr_t last_reg;
  logic           have_reg;
  logic           tmr_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !o_running) have_reg <= 1'b0;
    else if (o_mem_rd && i_mem_gnt) have_reg <= 1'b1;
    if (o_mem_rd && i_mem_gnt) last_reg <= o_mem_addr;
    if (i_rst) tmr_reg <= 1'b0;
    else if (i_reg_wr && i_reg_addr == 8'h00) tmr_reg <= i_reg_wdata[1];
  end
  // ==========================================
  // sequences
  sequence s_store_taken;
    o_mem_wr && i_mem_gnt;
  endsequence
  sequence s_fetch_soon;
    ##[1:3] o_mem_rd;
  endsequence
  sequence s_sw_start;
    i_reg_wr && i_reg_addr == 8'h00 && i_reg_wdata[0] && !o_running;
  endsequence
  // ==========================================
  // assertions
  a_rd_hold: assert property (o_mem_rd && !i_mem_gnt |=> o_mem_rd && $stable(o_mem_addr))
    else $error("fetch dropped before grant");
  a_wr_hold: assert property (o_mem_wr && !i_mem_gnt |=>
    o_mem_wr && $stable(o_mem_wdata) && $stable(o_mem_addr))
    else $error("store dropped before grant");
  a_store_half: assert property (o_mem_wr |-> o_mem_wdata[20:16] == 5'h00)
    else $error("store gap bits not zero");
  a_pc_step: assert property ($rose(o_mem_rd) && have_reg |-> o_mem_addr == last_reg + 11'h001)
    else $error("fetch address not next word");
  a_halt_idle: assert property (o_halted |-> !o_running && $past(o_running))
    else $error("halt pulse without stop");
  a_sw_start: assert property (s_sw_start |=> o_running && o_mem_rd)
    else $error("software start ignored");
  a_tmr_start: assert property (i_timer_tick && tmr_reg && !o_running |=> o_running)
    else $error("timer start ignored");
  a_event_pulse: assert property (o_wake_req || o_cpu_irq |->
    !(o_wake_req && o_cpu_irq) ##1 !(o_wake_req || o_cpu_irq))
    else $error("event not a single pulse");
  a_store_resume: assert property (s_store_taken |-> s_fetch_soon)
    else $error("no fetch after store");
endmodule

/* File: testbench/lpc_mem_model.sv */
// shared slow memory, optionally granting every other cycle
`timescale 1ns/10ps
module lpc_mem_model (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_slow,
  input  wire logic                    i_rd,
  input  wire logic                    i_wr,
  input  wire lpc_pkg::lpc_word_addr_t i_addr,
  input  wire logic [31:0]             i_wdata,
  output logic                         o_gnt,
  output logic [31:0]                  o_rdata
);
  import lpc_pkg::*;
  logic [31:0] mem [2048];
  logic        tog_reg = 1'b0;
  assign o_gnt = (i_rd || i_wr) && (!i_slow || tog_reg);
  always @(posedge i_core_clk) begin
    tog_reg <= !tog_reg;
    if (i_wr && o_gnt) mem[i_addr] <= i_wdata;
    // read data valid one cycle only, then scrambled
    if (i_rd && o_gnt) o_rdata <= mem[i_addr];
    else o_rdata <= ~o_rdata;
  end
endmodule

/* File: testbench/test_low_power_coproc_alu_decode.sv */
// self-checking bench of the coprocessor core
`timescale 1ns/10ps
module test_low_power_coproc_alu_decode;
  import lpc_pkg::*;
  localparam logic [31:0] HALT_W = 32'hB000_0000;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_timer_tick = 1'b0, i_soc_asleep = 1'b0, slow = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0000_0000;
  logic [31:0] o_reg_rdata, o_mem_wdata, i_mem_rdata, rv;
  logic o_mem_rd, o_mem_wr, i_mem_gnt, o_wake_req, o_cpu_irq, o_halted, o_running;
  lpc_word_addr_t o_mem_addr, e;
  logic [31:0] p [6];
  logic [16:0] r;
  logic [15:0] va [7] = '{16'h8000, 16'h0001, 16'hF0F0, 16'hF000, 16'h1234, 16'h0001, 16'h8000};
  logic [15:0] vb [7] = '{16'h8000, 16'h0002, 16'h0FF0, 16'h000F, 16'h0000, 16'h0013, 16'h000F};
  int fails = 0, n_tests = 0, n_wake = 0, n_irq = 0;
  always #12.5 i_core_clk = ~i_core_clk;
  lpc_core u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_timer_tick(i_timer_tick), .i_soc_asleep(i_soc_asleep),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_gnt(i_mem_gnt), .i_mem_rdata(i_mem_rdata),
    .o_wake_req(o_wake_req), .o_cpu_irq(o_cpu_irq), .o_halted(o_halted), .o_running(o_running));
  lpc_mem_model u_mem (.i_core_clk(i_core_clk), .i_slow(slow), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_gnt(i_mem_gnt), .o_rdata(i_mem_rdata));
  always @(posedge i_core_clk) begin
    if (o_wake_req === 1'b1) n_wake++;
    if (o_cpu_irq === 1'b1) n_irq++;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] ai(logic [3:0] s, logic [15:0] m, logic [1:0] a, logic [1:0] d);
    return {4'h7, 3'h1, s, 1'b0, m, a, d};
  endfunction
  function automatic logic [31:0] ar(logic [3:0] s, logic [1:0] b, logic [1:0] a, logic [1:0] d);
    return {4'h7, 3'h0, s, 15'h0000, b, a, d};
  endfunction
  function automatic logic [31:0] sg(logic [3:0] s, logic [7:0] m);
    return {4'h7, 3'h2, s, 9'h000, m, 4'h0};
  endfunction
  function automatic logic [16:0] ealu(logic [3:0] s, logic [15:0] a, logic [15:0] b);
    case (s)
      4'h0: return {1'b0, a} + {1'b0, b};
      4'h1: return {1'b0, a} - {1'b0, b};
      4'h2: return {1'b0, a & b};
      4'h3: return {1'b0, a | b};
      4'h4: return {1'b0, a};
      4'h5: return {1'b0, a << b[3:0]};
      default: return {1'b0, a >> b[3:0]};
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  task automatic chk_idle();
    for (int a = 0; a < 36; a += 4) begin
      rd(8'(a), rv);
      chk(rv, 32'h0000_0000);
    end
    $display("reset test done");
  endtask
  // load program at e, start it, wait for halt
  task automatic go(input logic tmr);
    int k;
    for (k = 0; k < 6; k++) u_mem.mem[e + 11'(k)] = p[k];
    wr(8'h0C, {21'h0, e});
    if (tmr) begin
      wr(8'h00, 32'h0000_0002);
      @(posedge i_core_clk);
      i_timer_tick <= 1'b1;
      @(posedge i_core_clk);
      i_timer_tick <= 1'b0;
    end else wr(8'h00, 32'h0000_0001);
    for (k = 0; k < 400 && o_halted !== 1'b1; k++) @(posedge i_core_clk);
    if (k >= 400) fails++;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #500_000;
    fails++;
    complete_run();
  end
  // ==========================================
  // tests
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    chk_idle();
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 7; i++) begin
        e = 11'h100 + 11'(16 * i + 8 * f);
        r = ealu(4'(i), va[i], vb[i]);
        p = '{ai(4'h2, 16'h0000, 2'd0, 2'd0), ai(4'h0, va[i], 2'd0, 2'd0),
          ai(4'h2, 16'h0000, 2'd1, 2'd1), ai(4'h0, vb[i], 2'd1, 2'd1),
          f ? ai(4'(i), vb[i], 2'd0, 2'd2) : ar(4'(i), 2'd1, 2'd0, 2'd2), HALT_W};
        go(i == 3);
        rd(8'h18, rv);
        chk(rv, {16'h0000, r[15:0]});
        rd(8'h04, rv);
        chk(rv, {29'h0, (i < 2 && r[16]), (r[15:0] == 16'h0000), 1'b0});
        rd(8'h08, rv);
        chk(rv, {21'h0, e + 11'h005});
      end
      $display("alu form %0d done", f);
    end
    e = 11'h300;
    p = '{sg(4'h2, 8'h00), sg(4'h0, 8'hF0), sg(4'h0, 8'h20), sg(4'h1, 8'h30), HALT_W, HALT_W};
    go(1'b0);
    rd(8'h04, rv);
    chk(rv[15:8], 32'h0000_00E0);
    e = 11'h308;
    p = '{sg(4'h2, 8'h00), HALT_W, HALT_W, HALT_W, HALT_W, HALT_W};
    go(1'b0);
    rd(8'h04, rv);
    chk(rv[15:8], 32'h0000_0000);
    $display("stage test done");
    slow <= 1'b1;
    u_mem.mem[3] = 32'h0000_0000;
    e = 11'h310;
    p = '{ai(4'h2, 16'h0000, 2'd0, 2'd0), ai(4'h0, 16'h0005, 2'd0, 2'd0),
      ai(4'h2, 16'h0000, 2'd1, 2'd1), ai(4'h0, 16'hBEEF, 2'd1, 2'd1),
      {4'h6, 3'h4, 4'h0, 11'h7FE, 6'h00, 2'd1, 2'd0}, HALT_W};
    go(1'b0);
    chk(u_mem.mem[3], {e + 11'h004, 5'h00, 16'hBEEF});
    slow <= 1'b0;
    $display("store test done");
    e = 11'h320;
    p = '{32'h9000_0001, HALT_W, HALT_W, HALT_W, HALT_W, HALT_W};
    i_soc_asleep <= 1'b1;
    go(1'b0);
    i_soc_asleep <= 1'b0;
    go(1'b0);
    repeat (2) @(posedge i_core_clk);
    chk({n_wake[15:0], n_irq[15:0]}, 32'h0001_0001);
    $display("event test done");
    e = 11'h330;
    p = '{ai(4'h0, 16'h00A5, 2'd3, 2'd3), HALT_W, HALT_W, HALT_W, HALT_W, HALT_W};
    for (int k = 0; k < 6; k++) u_mem.mem[e + 11'(k)] = p[k];
    wr(8'h0C, {21'h0, e});
    wr(8'h00, 32'h0000_0003);
    rd(8'h04, rv);
    chk(rv, 32'h0000_0001);
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    chk_idle();
    complete_run();
  end
endmodule
bind lpc_core lpc_core_props u_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_timer_tick(i_timer_tick), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
  .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_gnt(i_mem_gnt),
  .o_wake_req(o_wake_req), .o_cpu_irq(o_cpu_irq), .o_halted(o_halted), .o_running(o_running));
